// File: shared/aux_conv_pkg.sv
// Shared constants for the auxiliary converter and temperature sensor control block.
package aux_conv_pkg;
  localparam int ADDR_W = 7;
  localparam logic [6:0] CONV_CONFIG_ADDR = 7'h0f;
  localparam logic [6:0] BRIDGE_OFFSET_ADDR = 7'h10;
  localparam logic [6:0] CONV_RESULT_ADDR = 7'h11;
  localparam logic [6:0] TEMP_CTRL_ADDR = 7'h12;
  localparam logic [6:0] TEMP_OFFSET_ADDR = 7'h13;

  localparam logic [7:0] CONV_CONFIG_RST = 8'h00;
  localparam logic [3:0] BRIDGE_OFFSET_RST = 4'h0;
  localparam logic [7:0] CONV_RESULT_RST = 8'h00;
  localparam logic [7:0] TEMP_CTRL_RST = 8'h20;
  localparam logic [7:0] TEMP_OFFSET_RST = 8'h00;

  localparam int START_BIT = 7;
  localparam int SEL_HI = 6;
  localparam int SEL_LO = 4;
  localparam int REF_HI = 3;
  localparam int REF_LO = 2;
  localparam int GAIN_HI = 1;
  localparam int GAIN_LO = 0;
  localparam int BOFF_HI = 3;
  localparam int RANGE_HI = 7;
  localparam int RANGE_LO = 6;
  localparam int SHIFT_EN_BIT = 5;
  localparam int TRIM_EN_BIT = 4;
  localparam int TRIM_HI = 3;
  localparam int TRIM_LO = 2;
  localparam int BGTRIM_HI = 1;
  localparam int BGTRIM_LO = 0;

  localparam logic [2:0] TEMP_SENSOR_SEL = 3'h0;

  localparam int CLK_MHZ = 200;
  localparam int CONV_TIME_US = 350;
  localparam int CONV_CYCLES = CONV_TIME_US * CLK_MHZ;

  localparam logic [4:0] SPI_ADDR_BITS = 5'h08;
  localparam logic [4:0] SPI_FRAME_BITS = 5'h10;

  typedef enum logic [1:0] {
    CONV_IDLE = 2'b01,
    CONV_RUN  = 2'b10
  } conv_state_t;
endpackage

// File: hdl/spi_reg_port.sv
// Serial register port: one address byte and one data byte per select.
`timescale 1ns/100ps
module spi_reg_port
  import aux_conv_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic sclkPin,
  input wire logic spiSelN,
  input wire logic sdiPin,
  input wire logic [7:0] rdData,
  output logic [6:0] regAddr,
  output logic [7:0] wrData,
  output logic wrPulse,
  output logic sdo,
  output logic sdoOe
);
  logic [2:0] sclkSync;
  logic [1:0] selSync;
  logic [1:0] sdiSync;
  logic [4:0] bitCnt;
  logic [7:0] rxShift;
  logic [7:0] txShift;
  logic isWrite;

  // Pins are asynchronous, so the serial clock must run at most an eighth of clk.
  wire sclkRise = sclkSync[1] & ~sclkSync[2];
  wire sclkFall = ~sclkSync[1] & sclkSync[2];
  wire selected = ~selSync[1];
  wire [7:0] rxNext = {rxShift[6:0], sdiSync[1]};
  wire counting = selected && (bitCnt < SPI_FRAME_BITS);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclkSync <= 3'h0;
      selSync <= 2'h3;
      sdiSync <= 2'h0;
    end else begin
      sclkSync <= {sclkSync[1:0], sclkPin};
      selSync <= {selSync[0], spiSelN};
      sdiSync <= {sdiSync[0], sdiPin};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bitCnt <= 5'h00;
      rxShift <= 8'h00;
      regAddr <= 7'h00;
      isWrite <= 1'b0;
      wrData <= 8'h00;
      wrPulse <= 1'b0;
    end else begin
      wrPulse <= 1'b0;
      if (!selected) begin
        bitCnt <= 5'h00;
      end else if (sclkRise && counting) begin
        rxShift <= rxNext;
        bitCnt <= bitCnt + 5'h01;
        if (bitCnt == SPI_ADDR_BITS - 5'h01) begin
          isWrite <= rxNext[7];
          regAddr <= rxNext[6:0];
        end
        if (bitCnt == SPI_FRAME_BITS - 5'h01 && isWrite) begin
          wrData <= rxNext;
          wrPulse <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txShift <= 8'h00;
      sdo <= 1'b0;
      sdoOe <= 1'b0;
    end else begin
      sdoOe <= selected && !isWrite && (bitCnt >= SPI_ADDR_BITS);
      if (sclkFall && selected && !isWrite) begin
        if (bitCnt == SPI_ADDR_BITS) begin
          txShift <= rdData;
          sdo <= rdData[7];
        end else if (bitCnt > SPI_ADDR_BITS) begin
          txShift <= {txShift[6:0], 1'b0};
          sdo <= txShift[6];
        end
      end
    end
  end
endmodule

// File: hdl/aux_conv_ctrl.sv
// Control of the 8-bit auxiliary converter and on-chip temperature sensor.
//
// Operation
// - Writing one to the start bit of the configuration register begins a conversion.
// - The start bit clears itself when conversion ends, serving as busy flag.
// - A conversion lasts 350 microseconds from start until busy clears.
// - Bits 6:4 select converter input, bits 3:2 select its reference.
// - Configuration resets to zero: temperature sensor input, bandgap reference.
// - Bits 1:0 of configuration select the bridge amplifier gain.
// - Low nibble of bridge offset register sets supply-dependent offset; upper bits unused.
// - Temperature sensor powers on when selected as input or routed to test bus.
// - Range bits 7:6: 00 is -64..64 C half steps, 01 is -64..192 C.
// - Range 10 is 0..128 C half steps, 11 is -40..216 F.
// - With bit 5 set, the offset register is added to the reported result when the temperature sensor is the selected input.
// - With bit 5 clear the sensor is unshifted, a test mode; bit resets to one.
// - With bit 4 set, the trim field applies analog negative-capable compensation.
// - Temperature control resets to 20h; offsets and configuration reset to zero.
`timescale 1ns/100ps
module aux_conv_ctrl
  import aux_conv_pkg::*;
#(
  parameter int CONV_CYCLES_P = CONV_CYCLES
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic sclkPin,
  input wire logic spiSelN,
  input wire logic sdiPin,
  output logic sdo,
  output logic sdoOe,
  input wire logic [7:0] convRaw,
  input wire logic testBusTemp,
  output logic convStart,
  output logic [2:0] inputSelect,
  output logic [1:0] refSelect,
  output logic [1:0] gainSelect,
  output logic [3:0] bridgeOffset,
  output logic tempSensorOn,
  output logic [1:0] tempRange,
  output logic tempShiftEnable,
  output logic [1:0] trimCode,
  output logic [1:0] bandgapTrim
);
  logic [1:0] rstPipe;
  logic rstSync;
  logic [7:0] rawMeta;
  logic [7:0] rawSync;
  logic [1:0] testBusPipe;
  logic [6:0] regAddr;
  logic [7:0] wrData;
  logic wrPulse;
  logic [7:0] rdData;
  logic [7:0] convConfig_r;
  logic [7:0] tempCtrl_r;
  logic [7:0] tempOffset_r;
  logic [7:0] convResult_r;
  logic [7:0] convResult_nxt;
  logic [16:0] convCount_r;
  conv_state_t state_r;
  conv_state_t state_nxt;

  // Adds the digital offset, clipping at full scale so a large offset cannot wrap to a cold reading.
  function automatic logic [7:0] add_sat(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    add_sat = sum[8] ? 8'hff : sum[7:0];
  endfunction

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSync = rstPipe[1];

  // The analog code is steady when the conversion ends, so a plain two-stage sync per bit is safe.
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      rawMeta <= 8'h00;
      rawSync <= 8'h00;
      testBusPipe <= 2'h0;
    end else begin
      rawMeta <= convRaw;
      rawSync <= rawMeta;
      testBusPipe <= {testBusPipe[0], testBusTemp};
    end
  end

  spi_reg_port port (
    .clk(clk),
    .rstn(rstSync),
    .sclkPin(sclkPin),
    .spiSelN(spiSelN),
    .sdiPin(sdiPin),
    .rdData(rdData),
    .regAddr(regAddr),
    .wrData(wrData),
    .wrPulse(wrPulse),
    .sdo(sdo),
    .sdoOe(sdoOe)
  );

  wire busy = (state_r == CONV_RUN);
  wire wrConfig = wrPulse && (regAddr == CONV_CONFIG_ADDR);
  wire wrBridge = wrPulse && (regAddr == BRIDGE_OFFSET_ADDR);
  wire wrTempCtrl = wrPulse && (regAddr == TEMP_CTRL_ADDR);
  wire wrTempOffset = wrPulse && (regAddr == TEMP_OFFSET_ADDR);
  wire startReq = wrConfig && wrData[START_BIT];
  wire startTaken = startReq && !busy;
  wire convDone = busy && (convCount_r == 17'h00000);
  wire tempSelected = (convConfig_r[SEL_HI:SEL_LO] == TEMP_SENSOR_SEL);
  wire shiftOn = tempCtrl_r[SHIFT_EN_BIT];
  wire trimOn = tempCtrl_r[TRIM_EN_BIT];
  wire [7:0] configView = {busy, convConfig_r[6:0]};
  wire [7:0] bridgeView = {4'h0, bridgeOffset};
  assign rdData =
    (regAddr == CONV_CONFIG_ADDR) ? configView :
    (regAddr == BRIDGE_OFFSET_ADDR) ? bridgeView :
    (regAddr == CONV_RESULT_ADDR) ? convResult_r :
    (regAddr == TEMP_CTRL_ADDR) ? tempCtrl_r :
    (regAddr == TEMP_OFFSET_ADDR) ? tempOffset_r : 8'h00;
  wire [7:0] shiftedRaw = add_sat(rawSync, tempOffset_r);

  assign convResult_nxt = (tempSelected && shiftOn) ? shiftedRaw : rawSync;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      CONV_IDLE: begin
        if (startReq) begin
          state_nxt = CONV_RUN;
        end
      end
      CONV_RUN: begin
        if (convDone) begin
          state_nxt = CONV_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      state_r <= CONV_IDLE;
      convCount_r <= 17'h00000;
      convStart <= 1'b0;
      convResult_r <= CONV_RESULT_RST;
    end else begin
      state_r <= state_nxt;
      convStart <= startTaken;
      if (startTaken) begin
        convCount_r <= 17'(CONV_CYCLES_P - 1);
      end else if (busy && !convDone) begin
        convCount_r <= convCount_r - 17'h00001;
      end
      if (convDone) begin
        convResult_r <= convResult_nxt;
      end
    end
  end

  // The start bit itself is not stored; it reads back as the busy flag.
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      convConfig_r <= CONV_CONFIG_RST;
      bridgeOffset <= BRIDGE_OFFSET_RST;
      tempCtrl_r <= TEMP_CTRL_RST;
      tempOffset_r <= TEMP_OFFSET_RST;
    end else begin
      if (wrConfig) begin
        convConfig_r <= {1'b0, wrData[6:0]};
      end
      if (wrBridge) begin
        bridgeOffset <= wrData[BOFF_HI:0];
      end
      if (wrTempCtrl) begin
        tempCtrl_r <= wrData;
      end
      if (wrTempOffset) begin
        tempOffset_r <= wrData;
      end
    end
  end

  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      inputSelect <= 3'h0;
      refSelect <= 2'h0;
      gainSelect <= 2'h0;
      tempSensorOn <= 1'b0;
      tempRange <= 2'h0;
      tempShiftEnable <= 1'b0;
      trimCode <= 2'h0;
      bandgapTrim <= 2'h0;
    end else begin
      inputSelect <= convConfig_r[SEL_HI:SEL_LO];
      refSelect <= convConfig_r[REF_HI:REF_LO];
      gainSelect <= convConfig_r[GAIN_HI:GAIN_LO];
      tempSensorOn <= tempSelected || testBusPipe[1];
      tempRange <= tempCtrl_r[RANGE_HI:RANGE_LO];
      tempShiftEnable <= shiftOn;
      trimCode <= trimOn ? tempCtrl_r[TRIM_HI:TRIM_LO] : 2'h0;
      bandgapTrim <= tempCtrl_r[BGTRIM_HI:BGTRIM_LO];
    end
  end

  // Helper counter that measures how long busy stays high.
  int busyLen;
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      busyLen <= 0;
    end else if (startTaken) begin
      busyLen <= 0;
    end else if (busy) begin
      busyLen <= busyLen + 1;
    end
  end

  a_start_busy: assert property (@(posedge clk) disable iff (!rstSync)
    startReq && !busy |=> busy && configView[START_BIT] && convStart)
    else $error("start write did not raise busy");
  a_busy_length: assert property (@(posedge clk) disable iff (!rstSync)
    $fell(busy) |-> busyLen == CONV_CYCLES_P)
    else $error("conversion length is wrong");
  a_busy_selfclear: assert property (@(posedge clk) disable iff (!rstSync)
    convDone |=> !busy && configView[START_BIT] == 1'b0)
    else $error("busy did not clear at end of conversion");
  a_start_ignored: assert property (@(posedge clk) disable iff (!rstSync)
    busy && !convDone && startReq |=> busy && convCount_r == $past(convCount_r) - 17'h00001)
    else $error("start during conversion was not ignored");
  a_reset_values: assert property (@(posedge clk)
    $rose(rstSync) |-> convConfig_r == CONV_CONFIG_RST && tempCtrl_r == TEMP_CTRL_RST
      && tempOffset_r == TEMP_OFFSET_RST && bridgeOffset == BRIDGE_OFFSET_RST)
    else $error("register reset value is wrong");
  a_select_follow: assert property (@(posedge clk) disable iff (!rstSync)
    wrConfig |=> ##1 inputSelect == $past(wrData[SEL_HI:SEL_LO], 2)
      && refSelect == $past(wrData[REF_HI:REF_LO], 2) && gainSelect == $past(wrData[GAIN_HI:GAIN_LO], 2))
    else $error("converter selects did not follow the write");
  a_bridge_nibble: assert property (@(posedge clk) disable iff (!rstSync)
    wrBridge |=> bridgeOffset == $past(wrData[3:0]) && bridgeView[7:4] == 4'h0)
    else $error("bridge offset write lost");
  a_sensor_power: assert property (@(posedge clk) disable iff (!rstSync)
    rstSync |=> tempSensorOn == ($past(convConfig_r[SEL_HI:SEL_LO]) == 3'h0 || $past(testBusPipe[1])))
    else $error("temperature sensor power is wrong");
  a_range_follow: assert property (@(posedge clk) disable iff (!rstSync)
    wrTempCtrl |=> ##1 tempRange == $past(wrData[7:6], 2))
    else $error("range field did not follow the write");
  a_offset_added: assert property (@(posedge clk) disable iff (!rstSync)
    convDone && tempSelected && shiftOn |=>
      convResult_r == add_sat($past(rawSync), $past(tempOffset_r)))
    else $error("digital offset not applied");
  a_no_shift: assert property (@(posedge clk) disable iff (!rstSync)
    convDone && !shiftOn |=> convResult_r == $past(rawSync))
    else $error("unshifted result altered");
  a_trim_gate: assert property (@(posedge clk) disable iff (!rstSync)
    trimCode != 2'h0 |-> $past(trimOn))
    else $error("trim applied while disabled");
endmodule

// File: sim/spi_host_model.sv
// Host-side serial master that sends one register frame per select.
`timescale 1ns/100ps
module spi_host_model (
  input wire logic clk,
  output logic sclk,
  output logic selN,
  output logic sdi,
  input wire logic sdo
);
  // Each clock phase lasts eight system clocks, twice the minimum, so synchroniser slack never decides a bit.
  localparam int HALF = 8;
  initial begin
    sclk = 1'b0;
    selN = 1'b1;
    sdi = 1'b0;
  end
  task automatic waitClk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // A write of one to the start bit is sent twice per wanted conversion; the second lands while busy and is ignored.
  task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] word;
    word = {wr, addr, wd};
    rd = 8'h00;
    waitClk(1);
    selN = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi = word[i];
      waitClk(HALF);
      sclk = 1'b1;
      if (i < 8) rd[i] = sdo;
      waitClk(HALF);
      sclk = 1'b0;
    end
    waitClk(HALF);
    selN = 1'b1;
    // The released data line carries no stale copy of the last bit.
    sdi = ~sdi;
    waitClk(12);
  endtask
endmodule

// File: sim/aux_conv_ctrl_tb.sv
// Self-checking bench for the converter and temperature sensor control block.
`timescale 1ns/100ps
module aux_conv_ctrl_tb;
  import aux_conv_pkg::*;
  // Long enough to outlast two frames after the start and the read in the third, short enough to be done by the fourth.
  localparam int CYC = 850;
  logic clk, rstn, sclk, selN, sdi, sdo, sdoOe, testBusTemp, convStart, tempSensorOn, tempShiftEnable;
  logic [7:0] convRaw;
  logic [2:0] inputSelect;
  logic [1:0] refSelect, gainSelect, tempRange, trimCode, bandgapTrim;
  logic [3:0] bridgeOffset;
  int fails = 0;
  int nChecks = 0;
  int starts = 0;
  int oeCycles = 0;

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (convStart === 1'b1) starts++;
  // The data line may only be driven in the answer half of a read frame.
  always @(posedge clk) if (sdoOe === 1'b1) oeCycles++;

  spi_host_model host (.clk(clk), .sclk(sclk), .selN(selN), .sdi(sdi), .sdo(sdo));
  aux_conv_ctrl #(.CONV_CYCLES_P(CYC)) i_dut (.clk(clk), .rstn(rstn), .sclkPin(sclk), .spiSelN(selN),
    .sdiPin(sdi), .sdo(sdo), .sdoOe(sdoOe), .convRaw(convRaw), .testBusTemp(testBusTemp),
    .convStart(convStart), .inputSelect(inputSelect), .refSelect(refSelect), .gainSelect(gainSelect),
    .bridgeOffset(bridgeOffset), .tempSensorOn(tempSensorOn), .tempRange(tempRange),
    .tempShiftEnable(tempShiftEnable), .trimCode(trimCode), .bandgapTrim(bandgapTrim));

  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    nChecks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    int o0;
    o0 = oeCycles;
    host.xfer(1'b1, a, d, dummy);
    chk("sdoOe in write", 8'(oeCycles - o0), 8'h00);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] v;
    int o0;
    o0 = oeCycles;
    host.xfer(1'b0, a, 8'h00, v);
    chk($sformatf("register %h", a), v, exp);
    chk("sdoOe in read", 8'(oeCycles > o0), 8'h01);
  endtask
  task automatic conv(input logic [6:0] cfg, input logic [7:0] raw, input logic [7:0] exp);
    int s0;
    convRaw = raw;
    s0 = starts;
    wr(CONV_CONFIG_ADDR, {1'b1, cfg});
    rd(CONV_CONFIG_ADDR, {1'b1, cfg});
    wr(CONV_CONFIG_ADDR, {1'b1, cfg});
    rd(CONV_CONFIG_ADDR, {1'b1, cfg});
    rd(CONV_CONFIG_ADDR, {1'b0, cfg});
    rd(CONV_RESULT_ADDR, exp);
    chk("start pulses", 8'(starts - s0), 8'h01);
  endtask
  task automatic finishTest();
    $display("checks %0d, mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    convRaw = 8'h00;
    testBusTemp = 1'b0;
    repeat (8) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    rd(CONV_CONFIG_ADDR, 8'h00);
    rd(BRIDGE_OFFSET_ADDR, 8'h00);
    rd(CONV_RESULT_ADDR, 8'h00);
    rd(TEMP_CTRL_ADDR, 8'h20);
    rd(TEMP_OFFSET_ADDR, 8'h00);
    chk("tempShiftEnable", {7'h0, tempShiftEnable}, 8'h01);
    chk("tempSensorOn", {7'h0, tempSensorOn}, 8'h01);
    chk("selects", {1'b0, inputSelect, refSelect, gainSelect}, 8'h00);
    rd(7'h20, 8'h00);
    wr(CONV_RESULT_ADDR, 8'ha5);
    rd(CONV_RESULT_ADDR, 8'h00);
    $display("test reset_and_access done");
    wr(BRIDGE_OFFSET_ADDR, 8'hff);
    rd(BRIDGE_OFFSET_ADDR, 8'h0f);
    chk("bridgeOffset", {4'h0, bridgeOffset}, 8'h0f);
    wr(CONV_CONFIG_ADDR, 8'h3e);
    rd(CONV_CONFIG_ADDR, 8'h3e);
    chk("selects", {1'b0, inputSelect, refSelect, gainSelect}, 8'h3e);
    chk("tempSensorOn", {7'h0, tempSensorOn}, 8'h00);
    testBusTemp = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk("tempSensorOn", {7'h0, tempSensorOn}, 8'h01);
    testBusTemp = 1'b0;
    $display("test config_fields done");
    for (int r = 0; r < 4; r++) begin
      wr(TEMP_CTRL_ADDR, {2'(r), 6'h39});
      rd(TEMP_CTRL_ADDR, {2'(r), 6'h39});
      chk("tempRange", {6'h0, tempRange}, 8'(r));
      chk("trim", {4'h0, trimCode, bandgapTrim}, 8'h09);
    end
    wr(TEMP_CTRL_ADDR, 8'h1e);
    chk("tempShiftEnable", {7'h0, tempShiftEnable}, 8'h00);
    chk("trim", {4'h0, trimCode, bandgapTrim}, 8'h0e);
    wr(TEMP_CTRL_ADDR, 8'h2c);
    chk("trim", {4'h0, trimCode, bandgapTrim}, 8'h00);
    $display("test temp_control done");
    wr(TEMP_OFFSET_ADDR, 8'h10);
    rd(TEMP_OFFSET_ADDR, 8'h10);
    wr(TEMP_CTRL_ADDR, 8'h20);
    conv(7'h00, 8'h40, 8'h50);
    conv(7'h00, 8'hf8, 8'hff);
    wr(TEMP_CTRL_ADDR, 8'h00);
    conv(7'h00, 8'h40, 8'h40);
    wr(TEMP_CTRL_ADDR, 8'h20);
    conv(7'h3e, 8'h33, 8'h33);
    $display("test conversions done");
    finishTest();
  end
endmodule
